// ---- src/registered_bus_transceiver.v ----
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "rbt_map.vh"

module registered_bus_transceiver #(
	parameter W = `RBT_W
) (
	input wire clock,
	input wire rst_n,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire [1:0] outEnableN,
	input wire [1:0] direction,
	input wire [1:0] a_capture_clock,
	input wire [1:0] b_capture_clock,
	input wire [1:0] b_out_source_select,
	input wire [1:0] a_out_source_select,
	input wire [2*W-1:0] portALinesIn,
	output wire [2*W-1:0] portALinesOut,
	output wire [2*W-1:0] portALinesOe,
	input wire [2*W-1:0] portBLinesIn,
	output wire [2*W-1:0] portBLinesOut,
	output wire [2*W-1:0] portBLinesOe
);

	// ****************************************
	// control register
	// ****************************************
	reg [1:0] ctrl_r;
	wire outAllow = ctrl_r[`RBT_CTRL_EN];
	wire gang = ctrl_r[`RBT_CTRL_GANG];

	// ****************************************
	// channel pin bundles
	// ****************************************
	// bit positions come from the map, not from concatenation order
	function [`RBT_NCTL-1:0] bundle;
		input oeN;
		input dir;
		input aClk;
		input bClk;
		input bSel;
		input aSel;
		begin
			bundle = {`RBT_NCTL{1'b0}};
			bundle[`RBT_C_OEN] = oeN;
			bundle[`RBT_C_DIR] = dir;
			bundle[`RBT_C_ACLK] = aClk;
			bundle[`RBT_C_BCLK] = bClk;
			bundle[`RBT_C_BSEL] = bSel;
			bundle[`RBT_C_ASEL] = aSel;
		end
	endfunction

	wire [`RBT_NCTL-1:0] ctl0 = bundle(outEnableN[0], direction[0],
		a_capture_clock[0], b_capture_clock[0],
		b_out_source_select[0], a_out_source_select[0]);
	wire [`RBT_NCTL-1:0] ctl1Own = bundle(outEnableN[1], direction[1],
		a_capture_clock[1], b_capture_clock[1],
		b_out_source_select[1], a_out_source_select[1]);
	// joined mode: the upper half follows the lower half's controls
	wire [`RBT_NCTL-1:0] ctl1 = gang ? ctl0 : ctl1Own;

	// ****************************************
	// channel outputs
	// ****************************************
	wire [W-1:0] aOut0, aOut1, bOut0, bOut1;
	wire aOe0, aOe1, bOe0, bOe1;
	wire [W-1:0] aStore0, aStore1, bStore0, bStore1;
	wire [1:0] valid0, valid1;
	wire aCap0, aCap1, bCap0, bCap1;
	wire [`RBT_NCTL-1:0] lvl0, lvl1;

	// ****************************************
	// lower channel
	// ****************************************
	channel_core #(
		.W(W)
	) u_ch0 (
		.clock(clock),
		.rst_n(rst_n),
		.outAllow(outAllow),
		.ctlPin(ctl0),
		.aIn(portALinesIn[W-1:0]),
		.bIn(portBLinesIn[W-1:0]),
		.aOut_r(aOut0),
		.aOe_r(aOe0),
		.bOut_r(bOut0),
		.bOe_r(bOe0),
		.aStore_r(aStore0),
		.bStore_r(bStore0),
		.storeValid_r(valid0),
		.aCapPulse_r(aCap0),
		.bCapPulse_r(bCap0),
		.ctlLevel_r(lvl0)
	);

	// ****************************************
	// upper channel
	// ****************************************
	channel_core #(
		.W(W)
	) u_ch1 (
		.clock(clock),
		.rst_n(rst_n),
		.outAllow(outAllow),
		.ctlPin(ctl1),
		.aIn(portALinesIn[2*W-1:W]),
		.bIn(portBLinesIn[2*W-1:W]),
		.aOut_r(aOut1),
		.aOe_r(aOe1),
		.bOut_r(bOut1),
		.bOe_r(bOe1),
		.aStore_r(aStore1),
		.bStore_r(bStore1),
		.storeValid_r(valid1),
		.aCapPulse_r(aCap1),
		.bCapPulse_r(bCap1),
		.ctlLevel_r(lvl1)
	);

	// ****************************************
	// pins
	// ****************************************
	// each enable is one flop fanned out across its eight lines
	assign portALinesOut = {aOut1, aOut0};
	assign portBLinesOut = {bOut1, bOut0};
	assign portALinesOe = {{W{aOe1}}, {W{aOe0}}};
	assign portBLinesOe = {{W{bOe1}}, {W{bOe0}}};

	// ****************************************
	// capture counters
	// ****************************************
	// word decode: byte lanes of the address are ignored
	function wordHit;
		input [7:0] adr;
		input [7:0] off;
		begin
			wordHit = ({adr[7:2], 2'b00} == off);
		end
	endfunction

	// order: ch0 a, ch0 b, ch1 a, ch1 b, one byte each
	reg [7:0] cnt0_r, cnt1_r, cnt2_r, cnt3_r;
	wire access = cyc_i & stb_i & ~ack_o;
	wire wrHit = access & we_i;
	wire [7:0] adrWord = {adr_i[7:2], 2'b00};
	wire cntWr = wrHit & wordHit(adr_i, `RBT_OFF_COUNT);
	wire ctrlWr = wrHit & sel_i[0] & wordHit(adr_i, `RBT_OFF_CTRL);
	wire [3:0] cntClr = {4{cntWr}} & sel_i;

	// a capture in the same cycle as a clear still counts
	// counts wrap at the byte width, the carry is dropped on purpose
	function [7:0] cntNext;
		input [7:0] cur;
		input clr;
		input evt;
		reg [8:0] sum;
		begin
			sum = cur + `RBT_CNT_ONE;
			if (clr && evt)
				cntNext = `RBT_CNT_ONE;
			else if (clr)
				cntNext = `RBT_CNT_ZERO;
			else if (evt)
				cntNext = sum[7:0];
			else
				cntNext = cur;
		end
	endfunction

	always @(posedge clock) begin
		if (!rst_n) begin
			cnt0_r <= `RBT_CNT_ZERO;
			cnt1_r <= `RBT_CNT_ZERO;
			cnt2_r <= `RBT_CNT_ZERO;
			cnt3_r <= `RBT_CNT_ZERO;
		end else begin
			cnt0_r <= cntNext(cnt0_r, cntClr[0], aCap0);
			cnt1_r <= cntNext(cnt1_r, cntClr[1], bCap0);
			cnt2_r <= cntNext(cnt2_r, cntClr[2], aCap1);
			cnt3_r <= cntNext(cnt3_r, cntClr[3], bCap1);
		end
	end

	// ****************************************
	// read decode
	// ****************************************
	reg [31:0] rdData;

	always @* begin
		case (adrWord)
		`RBT_OFF_CTRL: begin
			rdData = {30'h0, ctrl_r};
		end
		`RBT_OFF_STATUS: begin
			rdData = {16'h0, lvl1, lvl0, valid1, valid0};
		end
		`RBT_OFF_STORE0: begin
			rdData = {16'h0, bStore0, aStore0};
		end
		`RBT_OFF_STORE1: begin
			rdData = {16'h0, bStore1, aStore1};
		end
		`RBT_OFF_COUNT: begin
			rdData = {cnt3_r, cnt2_r, cnt1_r, cnt0_r};
		end
		default: begin
			// unmapped words still answer, reading zero
			rdData = `RBT_ZERO;
		end
		endcase
	end

	// ****************************************
	// wishbone acknowledge
	// ****************************************
	// one wait state: ack one edge after the request, then dropped
	always @(posedge clock) begin
		if (!rst_n) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	// ****************************************
	// wishbone read data
	// ****************************************
	// zero outside a read answer, so no stale word lingers on the bus
	always @(posedge clock) begin
		if (!rst_n) begin
			dat_o <= `RBT_ZERO;
		end else if (access && !we_i) begin
			dat_o <= rdData;
		end else if (!access) begin
			dat_o <= `RBT_ZERO;
		end
	end

	// ****************************************
	// control register write
	// ****************************************
	// outputs stay off until software allows them
	always @(posedge clock) begin
		if (!rst_n) begin
			ctrl_r <= `RBT_CTRL_RST;
		end else if (ctrlWr) begin
			ctrl_r <= dat_i[1:0];
		end
	end
endmodule // registered_bus_transceiver

// ---- inc/rbt_map.vh ----
`ifndef RBT_MAP_VH
`define RBT_MAP_VH

// ****************************************
// channel geometry
// ****************************************
`define RBT_W 8
`define RBT_NCH 2

// ****************************************
// control pin order inside a channel
// ****************************************
`define RBT_NCTL 6
`define RBT_C_OEN 0
`define RBT_C_DIR 1
`define RBT_C_ACLK 2
`define RBT_C_BCLK 3
`define RBT_C_BSEL 4
`define RBT_C_ASEL 5
`define RBT_CTL_RST 6'h01

// ****************************************
// pin settling after reset
// ****************************************
`define RBT_SETTLE 2'h3
`define RBT_SETTLE_INC 2'h1

// ****************************************
// register map, byte addresses
// ****************************************
`define RBT_OFF_CTRL 8'h00
`define RBT_OFF_STATUS 8'h04
`define RBT_OFF_STORE0 8'h08
`define RBT_OFF_STORE1 8'h0c
`define RBT_OFF_COUNT 8'h10
`define RBT_CTRL_EN 0
`define RBT_CTRL_GANG 1
`define RBT_CTRL_RST 2'h0
`define RBT_ZERO 32'h00000000
`define RBT_CNT_ONE 8'h01
`define RBT_CNT_ZERO 8'h00

`endif

// ---- src/channel_core.v ----
`timescale 1ns/1ns
`include "rbt_map.vh"

module channel_core #(
	parameter W = `RBT_W
) (
	input wire clock,
	input wire rst_n,
	input wire outAllow,
	input wire [`RBT_NCTL-1:0] ctlPin,
	input wire [W-1:0] aIn,
	input wire [W-1:0] bIn,
	output reg [W-1:0] aOut_r,
	output reg aOe_r,
	output reg [W-1:0] bOut_r,
	output reg bOe_r,
	output reg [W-1:0] aStore_r,
	output reg [W-1:0] bStore_r,
	output reg [1:0] storeValid_r,
	output reg aCapPulse_r,
	output reg bCapPulse_r,
	output reg [`RBT_NCTL-1:0] ctlLevel_r
);
	localparam N = `RBT_NCTL + 2 * W;

	// ****************************************
	// pin filter
	// ****************************************
	// a bit moves only once stages two and three agree
	function [N-1:0] agree;
		input [N-1:0] held;
		input [N-1:0] s2;
		input [N-1:0] s3;
		reg [N-1:0] same;
		begin
			same = ~(s2 ^ s3);
			agree = (held & ~same) | (s3 & same);
		end
	endfunction

	reg [N-1:0] s1_r, s2_r, s3_r, held_r;
	reg [1:0] settle_r;
	wire [2:0] settleSum = settle_r + `RBT_SETTLE_INC;
	wire [N-1:0] heldNxt = agree(held_r, s2_r, s3_r);
	wire [N-1:0] heldRst = {{(2*W){1'b0}}, `RBT_CTL_RST};
	wire settled = (settle_r == `RBT_SETTLE);
	wire [W-1:0] aLive = heldNxt[`RBT_NCTL +: W];
	wire [W-1:0] bLive = heldNxt[`RBT_NCTL+W +: W];
	wire [`RBT_NCTL-1:0] c = held_r[`RBT_NCTL-1:0];

	always @(posedge clock) begin
		s1_r <= {bIn, aIn, ctlPin};
		s2_r <= s1_r;
		s3_r <= s2_r;
		if (!rst_n) begin
			held_r <= heldRst;
			settle_r <= 2'h0;
		end else begin
			held_r <= heldNxt;
			if (!settled)
				settle_r <= settleSum[1:0];
		end
	end

	// ****************************************
	// capture
	// ****************************************
	// no edge counts until the filter holds real pin levels
	wire aEdge = settled & heldNxt[`RBT_C_ACLK] & ~c[`RBT_C_ACLK];
	wire bEdge = settled & heldNxt[`RBT_C_BCLK] & ~c[`RBT_C_BCLK];
	// a driven port stores what the channel itself puts out
	wire [W-1:0] aCap = aOe_r ? aOut_r : aLive;
	wire [W-1:0] bCap = bOe_r ? bOut_r : bLive;

	// no reset: contents unknown until the first capture edge
	always @(posedge clock) begin
		if (aEdge)
			aStore_r <= aCap;
		if (bEdge)
			bStore_r <= bCap;
	end

	// ****************************************
	// drive
	// ****************************************
	wire drvOk = outAllow & settled & ~c[`RBT_C_OEN];

	always @(posedge clock) begin
		if (!rst_n) begin
			aOe_r <= 1'b0;
			bOe_r <= 1'b0;
			aOut_r <= {W{1'b0}};
			bOut_r <= {W{1'b0}};
			storeValid_r <= 2'b00;
			aCapPulse_r <= 1'b0;
			bCapPulse_r <= 1'b0;
			ctlLevel_r <= `RBT_CTL_RST;
		end else begin
			aOe_r <= drvOk & ~c[`RBT_C_DIR];
			bOe_r <= drvOk & c[`RBT_C_DIR];
			// registered mux: select changes cannot glitch the pins
			aOut_r <= c[`RBT_C_ASEL] ? bStore_r : bLive;
			bOut_r <= c[`RBT_C_BSEL] ? aStore_r : aLive;
			storeValid_r <= storeValid_r | {bEdge, aEdge};
			aCapPulse_r <= aEdge;
			bCapPulse_r <= bEdge;
			ctlLevel_r <= c;
		end
	end
endmodule // channel_core

// ---- bench/rbt_chk.sv ----
`timescale 1ns/1ns
// ****************************************
// port checks
// ****************************************
module rbt_chk (
	input logic clock,
	input logic rst_n,
	input logic cyc_i,
	input logic stb_i,
	input logic ack_o,
	input logic [31:0] dat_o,
	input logic [1:0] outEnableN,
	input logic [1:0] direction,
	input logic [1:0] b_out_source_select,
	input logic [15:0] portALinesIn,
	input logic [15:0] portALinesOe,
	input logic [15:0] portBLinesOut,
	input logic [15:0] portBLinesOe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// pins pass a filter: data lags 4 edges, controls 5
	oe_gate_a: assert property ($past(outEnableN[0], 4) &&
		$past(outEnableN[0], 5) |-> portALinesOe[7:0] == 8'h00 &&
		portBLinesOe[7:0] == 8'h00) else $error("ch0 drives while off");
	oe_gate_hi_a: assert property ($past(outEnableN[1], 4) &&
		$past(outEnableN[1], 5) |-> portALinesOe[15:8] == 8'h00 &&
		portBLinesOe[15:8] == 8'h00) else $error("ch1 drives while off");
	one_side_a: assert property (!((|portALinesOe[7:0]) &&
		(|portBLinesOe[7:0]))) else $error("both buses driven");
	a_dir_a: assert property (|portALinesOe[7:0] &&
		$past(direction[0], 4) == $past(direction[0], 5) |->
		!$past(direction[0], 5)) else $error("A driven with dir high");
	live_b_a: assert property (portBLinesOe[0] &&
		!$past(b_out_source_select[0], 4) &&
		!$past(b_out_source_select[0], 5) |->
		portBLinesOut[7:0] == $past(portALinesIn[7:0], 4))
		else $error("B output not live A");
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h00000000)
		else $error("read data outside ack");
endmodule // rbt_chk

// ---- bench/far_bus.sv ----
`timescale 1ns/1ns
// ****************************************
// far-side bus owners
// ****************************************
module far_bus (
	input logic [15:0] aDrv,
	input logic [15:0] bDrv,
	input logic [15:0] portALinesOut,
	input logic [15:0] portALinesOe,
	input logic [15:0] portBLinesOut,
	input logic [15:0] portBLinesOe,
	output logic [15:0] portALinesIn,
	output logic [15:0] portBLinesIn
);
	// far side backs off bitwise wherever the channel drives; drv keeps
	// its last level, so no float reaches the design
	assign portALinesIn = (portALinesOe & portALinesOut) |
		(~portALinesOe & aDrv);
	assign portBLinesIn = (portBLinesOe & portBLinesOut) |
		(~portBLinesOe & bDrv);
endmodule // far_bus

// ---- bench/registered_bus_transceiver_tb.sv ----
`timescale 1ns/1ns
`include "rbt_map.vh"
// ****************************************
// bench top
// ****************************************
module registered_bus_transceiver_tb;
	logic clock, rst_n, cyc_i, stb_i, we_i, ack_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q, seed;
	logic [1:0] outEnableN, direction, a_capture_clock, b_capture_clock;
	logic [1:0] b_out_source_select, a_out_source_select;
	logic [15:0] portALinesIn, portALinesOut, portALinesOe, aDrv;
	logic [15:0] portBLinesIn, portBLinesOut, portBLinesOe, bDrv;
	logic [7:0] storeA[2], storeB[2];
	int fails, testsRun, n;
	registered_bus_transceiver dut_u (
		.clock(clock),
		.rst_n(rst_n),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.outEnableN(outEnableN),
		.direction(direction),
		.a_capture_clock(a_capture_clock),
		.b_capture_clock(b_capture_clock),
		.b_out_source_select(b_out_source_select),
		.a_out_source_select(a_out_source_select),
		.portALinesIn(portALinesIn),
		.portALinesOut(portALinesOut),
		.portALinesOe(portALinesOe),
		.portBLinesIn(portBLinesIn),
		.portBLinesOut(portBLinesOut),
		.portBLinesOe(portBLinesOe)
	);
	far_bus far_u (
		.aDrv(aDrv),
		.bDrv(bDrv),
		.portALinesOut(portALinesOut),
		.portALinesOe(portALinesOe),
		.portBLinesOut(portBLinesOut),
		.portBLinesOe(portBLinesOe),
		.portALinesIn(portALinesIn),
		.portBLinesIn(portBLinesIn)
	);
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task summarize();
		$display("checks %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// master never assumes a latency, only the bounded wait
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (ack_o !== 1'b1) begin
			fails++;
			summarize();
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		rst_n = 1'b0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		sel_i = 4'hf;
		seed = 32'h0000002a;
		fails = 0;
		testsRun = 0;
		outEnableN = 2'h3;
		{direction, a_capture_clock, b_capture_clock} = '0;
		{b_out_source_select, a_out_source_select, aDrv, bDrv} = '0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (8) @(posedge clock);
		wb(0, `RBT_OFF_CTRL, 0);
		chk(q, 0);
		wb(0, 8'h20, 0);
		chk(q, 0);
		wb(1, `RBT_OFF_CTRL, 1);
		wb(0, `RBT_OFF_CTRL, 0);
		chk(q, 1);
		$display("register test done");
		for (int c = 0; c < 2; c++) begin
			aDrv[c*8 +: 8] <= rnd();
			bDrv[c*8 +: 8] <= rnd();
			repeat (6) @(posedge clock);
			storeA[c] = aDrv[c*8 +: 8];
			storeB[c] = bDrv[c*8 +: 8];
			// both clocks at once while isolated
			a_capture_clock[c] <= 1'b1;
			b_capture_clock[c] <= 1'b1;
			repeat (6) @(posedge clock);
			a_capture_clock[c] <= 1'b0;
			b_capture_clock[c] <= 1'b0;
			repeat (6) @(posedge clock);
			wb(0, c ? `RBT_OFF_STORE1 : `RBT_OFF_STORE0, 0);
			chk(q, {16'h0000, storeB[c], storeA[c]});
			for (int m = 0; m < 4; m++) begin
				outEnableN[c] <= 1'b0;
				direction[c] <= m[1];
				if (m[1]) begin
					b_out_source_select[c] <= m[0];
					aDrv[c*8 +: 8] <= rnd();
				end else begin
					a_out_source_select[c] <= m[0];
					bDrv[c*8 +: 8] <= rnd();
				end
				repeat (12) @(posedge clock);
				if (m[1]) begin
					chk({portALinesOe[c*8 +: 8], portBLinesOe[c*8 +: 8]}, 16'h00ff);
					chk(portBLinesOut[c*8 +: 8], m[0] ? storeA[c] : aDrv[c*8 +: 8]);
				end else begin
					chk({portALinesOe[c*8 +: 8], portBLinesOe[c*8 +: 8]}, 16'hff00);
					chk(portALinesOut[c*8 +: 8], m[0] ? storeB[c] : bDrv[c*8 +: 8]);
				end
				if (m == 0) begin
					// driving A: the A register takes what the channel puts out
					storeA[c] = bDrv[c*8 +: 8];
					a_capture_clock[c] <= 1'b1;
					repeat (6) @(posedge clock);
					a_capture_clock[c] <= 1'b0;
					repeat (6) @(posedge clock);
					wb(0, c ? `RBT_OFF_STORE1 : `RBT_OFF_STORE0, 0);
					chk(q, {16'h0000, storeB[c], storeA[c]});
				end
			end
			outEnableN[c] <= 1'b1;
			repeat (8) @(posedge clock);
			chk({portALinesOe[c*8 +: 8], portBLinesOe[c*8 +: 8]}, 0);
			$display("channel %0d test done", c);
		end
		wb(0, `RBT_OFF_STORE0, 0);
		chk(q, {16'h0000, storeB[0], storeA[0]});
		wb(0, `RBT_OFF_COUNT, 0);
		chk(q, 32'h01020102);
		wb(1, `RBT_OFF_COUNT, 0);
		wb(0, `RBT_OFF_COUNT, 0);
		chk(q, 0);
		// ch1 own direction says A, ganged it must follow ch0
		wb(1, `RBT_OFF_CTRL, 3);
		outEnableN <= 2'h0;
		direction <= 2'h1;
		b_out_source_select <= 2'h0;
		repeat (12) @(posedge clock);
		chk({portALinesOe, portBLinesOe}, 32'h0000ffff);
		chk(portBLinesOut, aDrv);
		$display("count and gang test done");
		summarize();
	end
endmodule // registered_bus_transceiver_tb
bind registered_bus_transceiver rbt_chk chk_u (
	.clock(clock),
	.rst_n(rst_n),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.ack_o(ack_o),
	.dat_o(dat_o),
	.outEnableN(outEnableN),
	.direction(direction),
	.b_out_source_select(b_out_source_select),
	.portALinesIn(portALinesIn),
	.portALinesOe(portALinesOe),
	.portBLinesOut(portBLinesOut),
	.portBLinesOe(portBLinesOe)
);
